/* ccnt_afe_model.sv */
// analog front-end stand-in answering conversion and calibration requests
module ccnt_afe_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        conv_start,
  input  wire logic        cal_active,
  input  wire logic [13:0] meas_val,
  input  wire logic [9:0]  cal_val,
  output logic             meas_toggle,
  output logic             cal_toggle,
  output logic      [13:0] meas_result,
  output logic      [9:0]  cal_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] m_sh;
  logic [3:0] c_sh;
  // result latched at the request, held well past its toggle for the syncs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      m_sh <= 4'h0;
      meas_toggle <= 1'b0;
      meas_result <= 14'h0000;
    end else begin
      m_sh <= {m_sh[2:0], conv_start};
      if (conv_start) meas_result <= meas_val;
      if (m_sh[3]) meas_toggle <= ~meas_toggle;
    end
  end
  // offset answered a few cycles after the sequence starts
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      c_sh <= 4'h0;
      cal_toggle <= 1'b0;
      cal_result <= 10'h000;
    end else begin
      c_sh <= {c_sh[2:0], cal_active};
      cal_result <= cal_val;
      if (c_sh[3:2] == 2'b01) cal_toggle <= ~cal_toggle;
    end
  end
endmodule // ccnt_afe_model

/* ccnt_cal.sv */
// auto-calibration sequencer: start, wait for the offset result
module ccnt_cal (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic result_evt,
  output logic      busy,
  output logic      load
);

  typedef enum logic {CCNT_CAL_IDLE, CCNT_CAL_RUN} ccnt_cal_state_t;

  ccnt_cal_state_t state_reg;

  // a start while running is ignored; a result while idle is ignored
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= CCNT_CAL_IDLE;
      busy      <= 1'b0;
      load      <= 1'b0;
    end else if (ce) begin
      load <= 1'b0;
      case (state_reg)
        CCNT_CAL_IDLE: begin
          if (start) begin
            state_reg <= CCNT_CAL_RUN; // RULE3
            busy      <= 1'b1;
          end
        end
        CCNT_CAL_RUN: begin
          if (result_evt) begin
            state_reg <= CCNT_CAL_IDLE;
            busy      <= 1'b0;
            load      <= 1'b1; // RULE10
          end
        end
        default: begin
          state_reg <= CCNT_CAL_IDLE;
          busy      <= 1'b0;
        end
      endcase
    end
  end

  property p_cal_start;
    @(posedge mclk) disable iff (sys_rst)
      (ce && start && !busy) |=> busy;
  endproperty
  a_cal_start: assert property (p_cal_start) // RULE3
    else $error("calibration did not start on request");

endmodule : ccnt_cal

/* ccnt_pkg.sv */
// shared constants and types of the coulomb counter register block
package ccnt_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL       = 8'hC0;
  localparam logic [7:0] ADDR_COUNT_B0   = 8'hC1;
  localparam logic [7:0] ADDR_COUNT_B1   = 8'hC2;
  localparam logic [7:0] ADDR_COUNT_B2   = 8'hC3;
  localparam logic [7:0] ADDR_ACCUM_B0   = 8'hC4;
  localparam logic [7:0] ADDR_ACCUM_B1   = 8'hC5;
  localparam logic [7:0] ADDR_ACCUM_B2   = 8'hC6;
  localparam logic [7:0] ADDR_ACCUM_B3   = 8'hC7;
  localparam logic [7:0] ADDR_OFFSET_LO  = 8'hC8;
  localparam logic [7:0] ADDR_OFFSET_HI  = 8'hC9;
  localparam logic [7:0] ADDR_INTEG_LO   = 8'hCA;
  localparam logic [7:0] ADDR_INTEG_HI   = 8'hCB;

  // field widths
  localparam int COUNT_W  = 24;
  localparam int ACCUM_W  = 32;
  localparam int OFFSET_W = 10;
  localparam int INTEG_W  = 14;

  // control field positions
  localparam int CTRL_RATE_LSB = 6;
  localparam int CTRL_CLEAR    = 2;
  localparam int CTRL_CAL      = 1;
  localparam int CTRL_INHIBIT  = 0;

  // reset values
  localparam logic [7:0]          CTRL_RESET   = 8'h00;
  localparam logic [COUNT_W-1:0]  COUNT_RESET  = 24'h000000;
  localparam logic [ACCUM_W-1:0]  ACCUM_RESET  = 32'h00000000;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 10'h000;
  localparam logic [INTEG_W-1:0]  INTEG_RESET  = 14'h0000;

  // conversion periods in microseconds and their cycle counts at mclk
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RATE0_US    = 250000;
  localparam int T_RATE1_US    = 62500;
  localparam int T_RATE2_US    = 15600;
  localparam int T_RATE3_US    = 3900;
  localparam int RATE0_CYC     = T_RATE0_US * 1000 / CLK_PERIOD_NS;
  localparam int RATE1_CYC     = T_RATE1_US * 1000 / CLK_PERIOD_NS;
  localparam int RATE2_CYC     = T_RATE2_US * 1000 / CLK_PERIOD_NS;
  localparam int RATE3_CYC     = T_RATE3_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W       = 24;

  // control register layout
  typedef struct packed {
    logic [1:0] rate;
    logic [2:0] rsvd;
    logic       clear;
    logic       cal;
    logic       inhibit;
  } ccnt_ctrl_t;

  // synchronised analog-side inputs
  typedef struct packed {
    logic [OFFSET_W-1:0] cal_val;
    logic [INTEG_W-1:0]  meas_val;
    logic                cal_tgl;
    logic                meas_tgl;
    logic                por_n;
  } ccnt_ana_t;

endpackage : ccnt_pkg

/* ccnt_regs.sv */
// coulomb counter register file, accumulator and control
//
// Behaviour
// [RULE1] Setting the clear bit zeroes offset, count and accumulator, then the bit drops itself.
// [RULE2] Writing 0 to the clear bit does nothing; only a 1 starts clearing.
// [RULE3] Writing 1 to the calibrate bit starts auto-calibration; writing 0 does nothing.
// [RULE4] While the inhibit bit is 1 no analog update reaches the result registers.
// [RULE5] The conversion count is 24 bits unsigned over three bytes, low byte first.
// [RULE6] The count steps once per conversion and zeroes on power-on reset low or clear.
// [RULE7] The accumulator is 32 bits two's complement over four bytes, low byte first.
// [RULE8] The accumulator sums results since power-on reset low or clear.
// [RULE9] The offset is 10 bits signed, low byte then bits 1:0 of the next byte.
// [RULE10] The offset register takes the offset measured during calibration.
// [RULE11] The integrator result is 14 bits signed, low byte then bits 5:0 of the next.
// [RULE12] The integrator result always shows the last completed conversion; the code skips conversions that land while inhibit is 1 or wipe is set.
// [RULE13] The rate field picks 250 ms, 62.5 ms, 15.6 ms or 3.9 ms per conversion.
// [RULE14] Each uninhibited conversion adds its result and steps the count together; the code drops a conversion that lands while wipe is set.
module ccnt_regs #(
  parameter int RATE0 = ccnt_pkg::RATE0_CYC,
  parameter int RATE1 = ccnt_pkg::RATE1_CYC,
  parameter int RATE2 = ccnt_pkg::RATE2_CYC,
  parameter int RATE3 = ccnt_pkg::RATE3_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          ce,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  input  wire logic                          power_on_reset_out_n,
  input  wire logic                          meas_toggle,
  input  wire logic [ccnt_pkg::INTEG_W-1:0]  meas_result,
  input  wire logic                          cal_toggle,
  input  wire logic [ccnt_pkg::OFFSET_W-1:0] cal_result,
  output logic                               conv_start,
  output logic                               cal_active
);

  localparam int SYNC_W = $bits(ccnt_pkg::ccnt_ana_t);

  logic [SYNC_W-1:0]                  sync1_reg;
  logic [SYNC_W-1:0]                  sync2_reg;
  logic [SYNC_W-1:0]                  ana_in;
  ccnt_pkg::ccnt_ana_t                ana;
  logic                               meas_tgl_d_reg;
  logic                               cal_tgl_d_reg;
  logic                               meas_evt;
  logic                               cal_evt;
  logic                               por_low;
  ccnt_pkg::ccnt_ctrl_t               ctrl_reg;
  logic [ccnt_pkg::COUNT_W-1:0]       count_reg;
  logic [ccnt_pkg::ACCUM_W-1:0]       accum_reg;
  logic [ccnt_pkg::OFFSET_W-1:0]      offset_reg;
  logic [ccnt_pkg::INTEG_W-1:0]       integ_reg;
  logic [ccnt_pkg::ACCUM_W-1:0]       meas_ext;
  logic                               wipe;
  logic                               upd_ok;
  logic                               cal_load;
  logic                               cal_go;
  logic                               cal_busy;
  logic                               tick;
  logic                               clear_set;

  // true when a host write hits the given address
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // pins packed in carrier order, so bit gi of each stage matches the ana field bit
  assign ana_in = {cal_result, meas_result, cal_toggle, meas_toggle, power_on_reset_out_n};

  // two-flop synchroniser on every analog-side input, bit by bit
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (ce) begin
          sync1_reg[gi] <= ana_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign ana = ccnt_pkg::ccnt_ana_t'(sync2_reg);

  // toggle edge detection, looks only at the second stage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meas_tgl_d_reg <= 1'b0;
      cal_tgl_d_reg  <= 1'b0;
    end else if (ce) begin
      meas_tgl_d_reg <= ana.meas_tgl;
      cal_tgl_d_reg  <= ana.cal_tgl;
    end
  end

  assign meas_evt = ana.meas_tgl ^ meas_tgl_d_reg;
  assign cal_evt  = ana.cal_tgl ^ cal_tgl_d_reg;
  assign por_low  = !ana.por_n;

  // clearing runs while the bit is set; power-on reset low clears too
  assign wipe      = ctrl_reg.clear || por_low; // RULE1 RULE6 RULE8
  assign upd_ok    = meas_evt && !ctrl_reg.inhibit && !wipe; // RULE4 RULE14
  assign cal_load  = cal_busy_load_q() && !ctrl_reg.inhibit && !wipe; // RULE4 RULE10
  assign meas_ext  = {{(ccnt_pkg::ACCUM_W - ccnt_pkg::INTEG_W){ana.meas_val[ccnt_pkg::INTEG_W-1]}},
                      ana.meas_val};
  assign clear_set = wr_hit(ccnt_pkg::ADDR_CTRL) && reg_wdata[ccnt_pkg::CTRL_CLEAR];
  assign cal_go    = wr_hit(ccnt_pkg::ADDR_CTRL) && reg_wdata[ccnt_pkg::CTRL_CAL]; // RULE3

  // calibration result arrives while the sequencer is running
  function automatic logic cal_busy_load_q();
    return cal_evt && cal_busy;
  endfunction

  ccnt_timer #(
    .RATE0 (RATE0),
    .RATE1 (RATE1),
    .RATE2 (RATE2),
    .RATE3 (RATE3)
  ) u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .rate    (ctrl_reg.rate),
    .tick    (tick)
  );

  ccnt_cal u_cal (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .start      (cal_go),
    .result_evt (cal_evt),
    .busy       (cal_busy),
    .load       ()
  );

  // control register; a new 1 on clear wins over the self-clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= ccnt_pkg::ccnt_ctrl_t'(ccnt_pkg::CTRL_RESET);
    end else if (ce) begin
      if (wr_hit(ccnt_pkg::ADDR_CTRL)) begin
        ctrl_reg.rate    <= reg_wdata[ccnt_pkg::CTRL_RATE_LSB +: 2]; // RULE13
        ctrl_reg.inhibit <= reg_wdata[ccnt_pkg::CTRL_INHIBIT]; // RULE4
      end
      ctrl_reg.rsvd <= 3'h0;
      ctrl_reg.cal  <= 1'b0;
      if (clear_set) begin
        ctrl_reg.clear <= 1'b1; // RULE2
      end else if (ctrl_reg.clear) begin
        ctrl_reg.clear <= 1'b0; // RULE1
      end
    end
  end

  // conversion count: clear first, then conversion, then host write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= ccnt_pkg::COUNT_RESET;
    end else if (ce) begin
      if (wipe) begin
        count_reg <= ccnt_pkg::COUNT_RESET; // RULE6
      end else if (upd_ok) begin
        count_reg <= count_reg + 1'b1; // RULE6 RULE14
      end else if (wr_hit(ccnt_pkg::ADDR_COUNT_B0)) begin
        count_reg[7:0] <= reg_wdata; // RULE5
      end else if (wr_hit(ccnt_pkg::ADDR_COUNT_B1)) begin
        count_reg[15:8] <= reg_wdata;
      end else if (wr_hit(ccnt_pkg::ADDR_COUNT_B2)) begin
        count_reg[23:16] <= reg_wdata;
      end
    end
  end

  // charge accumulator; wraps silently on overflow like the count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      accum_reg <= ccnt_pkg::ACCUM_RESET;
    end else if (ce) begin
      if (wipe) begin
        accum_reg <= ccnt_pkg::ACCUM_RESET; // RULE8
      end else if (upd_ok) begin
        accum_reg <= accum_reg + meas_ext; // RULE8 RULE14
      end else if (wr_hit(ccnt_pkg::ADDR_ACCUM_B0)) begin
        accum_reg[7:0] <= reg_wdata; // RULE7
      end else if (wr_hit(ccnt_pkg::ADDR_ACCUM_B1)) begin
        accum_reg[15:8] <= reg_wdata;
      end else if (wr_hit(ccnt_pkg::ADDR_ACCUM_B2)) begin
        accum_reg[23:16] <= reg_wdata;
      end else if (wr_hit(ccnt_pkg::ADDR_ACCUM_B3)) begin
        accum_reg[31:24] <= reg_wdata;
      end
    end
  end

  // calibration offset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      offset_reg <= ccnt_pkg::OFFSET_RESET;
    end else if (ce) begin
      if (wipe) begin
        offset_reg <= ccnt_pkg::OFFSET_RESET; // RULE1
      end else if (cal_load) begin
        offset_reg <= ana.cal_val; // RULE10
      end else if (wr_hit(ccnt_pkg::ADDR_OFFSET_LO)) begin
        offset_reg[7:0] <= reg_wdata; // RULE9
      end else if (wr_hit(ccnt_pkg::ADDR_OFFSET_HI)) begin
        offset_reg[9:8] <= reg_wdata[1:0];
      end
    end
  end

  // last integrator result; the clear bit does not touch it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      integ_reg <= ccnt_pkg::INTEG_RESET;
    end else if (ce) begin
      if (upd_ok) begin
        integ_reg <= ana.meas_val; // RULE12
      end else if (wr_hit(ccnt_pkg::ADDR_INTEG_LO)) begin
        integ_reg[7:0] <= reg_wdata; // RULE11
      end else if (wr_hit(ccnt_pkg::ADDR_INTEG_HI)) begin
        integ_reg[13:8] <= reg_wdata[5:0];
      end
    end
  end

  // registered read port; unmapped addresses and reserved bits read 0
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        ccnt_pkg::ADDR_CTRL:      reg_rdata <= {ctrl_reg.rate, 3'h0, ctrl_reg.clear,
                                                cal_busy, ctrl_reg.inhibit};
        ccnt_pkg::ADDR_COUNT_B0:  reg_rdata <= count_reg[7:0]; // RULE5
        ccnt_pkg::ADDR_COUNT_B1:  reg_rdata <= count_reg[15:8];
        ccnt_pkg::ADDR_COUNT_B2:  reg_rdata <= count_reg[23:16];
        ccnt_pkg::ADDR_ACCUM_B0:  reg_rdata <= accum_reg[7:0]; // RULE7
        ccnt_pkg::ADDR_ACCUM_B1:  reg_rdata <= accum_reg[15:8];
        ccnt_pkg::ADDR_ACCUM_B2:  reg_rdata <= accum_reg[23:16];
        ccnt_pkg::ADDR_ACCUM_B3:  reg_rdata <= accum_reg[31:24];
        ccnt_pkg::ADDR_OFFSET_LO: reg_rdata <= offset_reg[7:0]; // RULE9
        ccnt_pkg::ADDR_OFFSET_HI: reg_rdata <= {6'h00, offset_reg[9:8]};
        ccnt_pkg::ADDR_INTEG_LO:  reg_rdata <= integ_reg[7:0]; // RULE11
        ccnt_pkg::ADDR_INTEG_HI:  reg_rdata <= {2'h0, integ_reg[13:8]};
        default:                  reg_rdata <= 8'h00;
      endcase
    end
  end

  // conversion request to the analog integrator, one cycle per period
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
      cal_active <= 1'b0;
    end else if (ce) begin
      conv_start <= tick; // RULE13
      cal_active <= cal_go || (cal_busy && !cal_evt);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_clear_write;
    ce && clear_set && !ctrl_reg.clear;
  endsequence

  sequence s_clear_run;
    ce && ctrl_reg.clear;
  endsequence

  property p_clear_zero;
    s_clear_write ##1 s_clear_run |=>
      (count_reg == '0) && (accum_reg == '0) && (offset_reg == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) // RULE1
    else $error("clear did not zero the gauge results");

  property p_clear_self;
    (ce && ctrl_reg.clear && !clear_set) |=> !ctrl_reg.clear;
  endproperty
  a_clear_self: assert property (p_clear_self) // RULE1
    else $error("clear bit did not drop by itself");

  property p_write_zero;
    (ce && wr_hit(ccnt_pkg::ADDR_CTRL) && !reg_wdata[ccnt_pkg::CTRL_CLEAR] && !ctrl_reg.clear)
      |=> !ctrl_reg.clear;
  endproperty
  a_write_zero: assert property (p_write_zero) // RULE2
    else $error("writing 0 to clear had an effect");

  property p_inhibit;
    (ce && ctrl_reg.inhibit && !wipe && !reg_wr) |=>
      $stable(count_reg) && $stable(accum_reg) && $stable(integ_reg) && $stable(offset_reg);
  endproperty
  a_inhibit: assert property (p_inhibit) // RULE4
    else $error("result changed while updates were inhibited");

  property p_count_step;
    (ce && upd_ok) |=> (count_reg == $past(count_reg) + 24'h000001);
  endproperty
  a_count_step: assert property (p_count_step) // RULE6
    else $error("count did not step on a conversion");

  property p_accum_sum;
    (ce && upd_ok) |=> (accum_reg == $past(accum_reg) + $past(meas_ext));
  endproperty
  a_accum_sum: assert property (p_accum_sum) // RULE14
    else $error("accumulator did not add the signed result");

  property p_integ_last;
    (ce && upd_ok) |=> (integ_reg == $past(ana.meas_val));
  endproperty
  a_integ_last: assert property (p_integ_last) // RULE12
    else $error("integrator result is not the last conversion");

  property p_offset_load;
    (ce && cal_load) |=> (offset_reg == $past(ana.cal_val));
  endproperty
  a_offset_load: assert property (p_offset_load) // RULE10
    else $error("offset not loaded from calibration");

  property p_por_clear;
    (ce && por_low) |=> (count_reg == '0) && (accum_reg == '0);
  endproperty
  a_por_clear: assert property (p_por_clear) // RULE8
    else $error("power-on reset low did not clear results");

  property p_read_bytes;
    (ce && reg_rd && reg_addr == ccnt_pkg::ADDR_INTEG_HI) |=>
      (reg_rdata == {2'h0, $past(integ_reg[13:8])});
  endproperty
  a_read_bytes: assert property (p_read_bytes) // RULE11
    else $error("integrator high byte read back wrong");

  property p_read_count;
    (ce && reg_rd && reg_addr == ccnt_pkg::ADDR_COUNT_B2) |=>
      (reg_rdata == $past(count_reg[23:16]));
  endproperty
  a_read_count: assert property (p_read_count) // RULE5
    else $error("count top byte read back wrong");

  property p_read_accum;
    (ce && reg_rd && reg_addr == ccnt_pkg::ADDR_ACCUM_B0) |=>
      (reg_rdata == $past(accum_reg[7:0]));
  endproperty
  a_read_accum: assert property (p_read_accum) // RULE7
    else $error("accumulator low byte read back wrong");

  property p_read_offset;
    (ce && reg_rd && reg_addr == ccnt_pkg::ADDR_OFFSET_HI) |=>
      (reg_rdata == {6'h00, $past(offset_reg[9:8])});
  endproperty
  a_read_offset: assert property (p_read_offset) // RULE9
    else $error("offset high byte read back wrong");

endmodule : ccnt_regs

/* ccnt_timer.sv */
// conversion period timer driven by the update-rate select
module ccnt_timer #(
  parameter int RATE0 = ccnt_pkg::RATE0_CYC,
  parameter int RATE1 = ccnt_pkg::RATE1_CYC,
  parameter int RATE2 = ccnt_pkg::RATE2_CYC,
  parameter int RATE3 = ccnt_pkg::RATE3_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [1:0] rate,
  output logic            tick
);

  logic [ccnt_pkg::TIMER_W-1:0] cnt_reg;
  logic [ccnt_pkg::TIMER_W-1:0] period;

  // period select, a rate change takes effect at the next reload
  always_comb begin
    case (rate)
      2'h0:    period = ccnt_pkg::TIMER_W'(RATE0 - 1); // RULE13
      2'h1:    period = ccnt_pkg::TIMER_W'(RATE1 - 1);
      2'h2:    period = ccnt_pkg::TIMER_W'(RATE2 - 1);
      default: period = ccnt_pkg::TIMER_W'(RATE3 - 1);
    endcase
  end

  // down counter, one tick per elapsed period
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (ce) begin
      tick <= (cnt_reg == '0);
      if (cnt_reg == '0) begin
        cnt_reg <= period; // RULE13
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  property p_timer_reload;
    @(posedge mclk) disable iff (sys_rst)
      (ce && cnt_reg == '0) |=> (cnt_reg == $past(period));
  endproperty
  a_timer_reload: assert property (p_timer_reload) // RULE13
    else $error("timer did not reload the selected period");

endmodule : ccnt_timer

/* tb_top.sv */
// self-checking bench of the coulomb counter register block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [13:0] v;
    int          k;
    logic [1:0]  r;
    int          p;
  } ccnt_row_t;
  logic        mclk, sys_rst, reg_wr, reg_rd, por_n, ce;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        conv_start, cal_active, meas_toggle, cal_toggle;
  logic [13:0] meas_val, meas_result;
  logic [9:0]  cal_val, cal_result;
  logic [31:0] v;
  int          n_errors, check_count, c;
  // result value, conversions, rate code, period in cycles
  ccnt_row_t   rows [4] = '{'{14'h0005, 2, 2'h0, 80}, '{14'h3FFE, 3, 2'h1, 60},
                            '{14'h2000, 1, 2'h2, 40}, '{14'h1FFF, 2, 2'h3, 30}};

  // short periods keep the run brief
  ccnt_regs #(.RATE0(80), .RATE1(60), .RATE2(40), .RATE3(30)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_on_reset_out_n(por_n), .meas_toggle(meas_toggle),
    .meas_result(meas_result), .cal_toggle(cal_toggle), .cal_result(cal_result),
    .conv_start(conv_start), .cal_active(cal_active));
  ccnt_afe_model afe (
    .mclk(mclk), .sys_rst(sys_rst), .conv_start(conv_start),
    .cal_active(cal_active), .meas_val(meas_val), .cal_val(cal_val),
    .meas_toggle(meas_toggle), .cal_toggle(cal_toggle),
    .meas_result(meas_result), .cal_result(cal_result));

  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, exp, seen);
    end
  endtask

  task automatic final_report;
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // bytes read low address first, assembled low byte first
  task automatic rdn(logic [7:0] a, int n, output logic [31:0] r);
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      reg_addr <= a + 8'(i);
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 r[8*i +: 8] = reg_rdata;
    end
  endtask

  task automatic wait_conv(output int n);
    for (n = 1; n < 300; n++) begin
      @(posedge mclk);
      if (conv_start === 1'b1) return;
    end
    n_errors++;
    final_report;
  endtask

  // waits for a conversion answer, then lets its update land
  task automatic wait_tgl;
    logic t;
    t = meas_toggle;
    repeat (300) begin
      @(posedge mclk);
      if (meas_toggle !== t) begin
        repeat (6) @(posedge mclk);
        return;
      end
    end
    n_errors++;
    final_report;
  endtask

  // main sequence: reset values, table rows, then the awkward cases
  initial begin
    n_errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    por_n = 1'b1;
    ce = 1'b1;
    meas_val = 14'h0000;
    cal_val = 10'h000;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 12; a++) begin
      rdn(8'hC0 + 8'(a), 1, v);
      chk("reset value", v, 32'h0);
    end
    foreach (rows[i]) begin
      meas_val <= rows[i].v;
      wr(8'hC0, {rows[i].r, 6'h05});
      // measure the third pulse: the first may have been reloaded with the old rate
      wait_conv(c);
      wait_conv(c);
      wait_conv(c);
      chk("period", c, rows[i].p);
      wr(8'hC0, {rows[i].r, 6'h00});
      repeat (rows[i].k) wait_tgl;
      wr(8'hC0, {rows[i].r, 6'h01});
      wait_tgl;
      rdn(8'hC1, 3, v);
      chk("count", v, rows[i].k);
      rdn(8'hC4, 4, v);
      chk("accum", v, 32'(rows[i].k * $signed(rows[i].v)));
      rdn(8'hCA, 2, v);
      chk("integ", v, rows[i].v);
    end
    wr(8'hC0, 8'hC1);
    rdn(8'hC1, 3, v);
    chk("count kept", v, 32'h2);
    wr(8'hC1, 8'h5A);
    rdn(8'hC1, 1, v);
    chk("count write", v, 32'h5A);
    cal_val <= 10'h3A5;
    wr(8'hC0, 8'hC2);
    repeat (2) @(posedge mclk);
    chk("cal busy", cal_active, 32'h1);
    for (c = 0; c < 300 && cal_active !== 1'b0; c++) @(posedge mclk);
    chk("cal done", cal_active, 32'h0);
    if (c == 300) final_report;
    wr(8'hC0, 8'hC1);
    wait_tgl;
    chk("cal idle", cal_active, 32'h0);
    rdn(8'hC8, 2, v);
    chk("offset", v, 32'h3A5);
    wr(8'hC0, 8'hC5);
    repeat (3) @(posedge mclk);
    rdn(8'hC0, 1, v);
    chk("clear bit", v, 32'hC1);
    rdn(8'hC1, 3, v);
    chk("count clr", v, 32'h0);
    rdn(8'hC4, 4, v);
    chk("accum clr", v, 32'h0);
    rdn(8'hC8, 2, v);
    chk("offset clr", v, 32'h0);
    // power-on wipe of values written by the host
    wr(8'hC4, 8'h77);
    wr(8'hC1, 8'h33);
    por_n <= 1'b0;
    repeat (5) @(posedge mclk);
    por_n <= 1'b1;
    repeat (5) @(posedge mclk);
    rdn(8'hC1, 3, v);
    chk("count por", v, 32'h0);
    rdn(8'hC4, 4, v);
    chk("accum por", v, 32'h0);
    // clock enable low: a host write must be lost while frozen
    @(posedge mclk) ce <= 1'b0;
    wr(8'hC1, 8'h44);
    ce <= 1'b1;
    rdn(8'hC1, 1, v);
    chk("ce freeze", v, 32'h0);
    rdn(8'hCC, 1, v);
    chk("unmapped", v, 32'h0);
    final_report;
  end
endmodule // tb_top
